// [mps_sequencer.sv]
`timescale 1ns/1ps
`include "mps_cfg.svh"

// Overview of operation
// - Button gives short and long presses; a short press moves always-on or suspend to runtime.
// - Long press in runtime drops to always-on by hardware alone.
// - Main rail request high in runtime and suspend, low otherwise.
// - Standby rail request high in runtime; in suspend only with the keep bit set.
// - Software bit keeps standby rail request high during suspend.
// - Boot waits for power good; pulled up, floating means boot at once.
// - Held reset button also delays the boot start.
// - Boot starts at once when supply and power good are present.
// - Press from always-on or suspend restores full operation and runtime rails; a press in off is ignored.
// - Always-on keeps only button detection and clock logic alive.
// - Suspend keeps supplies on, powers cores down, runtime rails may drop.
// - Four-bit strap selects fuse, serial, card, removable card or flash.
// - Low alternate-boot input forces serial download over the usb port.
module mps_sequencer #(
  parameter int TICK_CYCLES = `MPS_TICK_US * `MPS_CLK_MHZ
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        power_button_n_in,
  input  wire logic        power_good_in,
  input  wire logic        reset_button_n_in,
  input  wire logic        alternate_boot_n_in,
  input  wire logic [3:0]  boot_select_strap_in,
  output logic             main_rail_request_out,
  output logic             standby_rail_request_out,
  output logic             core_power_out,
  output logic [3:0]       power_state_out,
  output logic [2:0]       boot_source_out,
  output logic             serial_download_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic       btn_pressed;
  logic       pg_ok;
  logic       rst_held;
  logic       alt_low;
  logic [3:0] strap_s;

  // Two flops per pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= `MPS_SYNC_RST;
      sync2_q <= `MPS_SYNC_RST;
    end else begin
      sync1_q <= {boot_select_strap_in, alternate_boot_n_in, reset_button_n_in,
                  power_good_in, power_button_n_in};
      sync2_q <= sync1_q;
    end
  end

  // Synchronised levels
  assign btn_pressed = !sync2_q[`MPS_SYN_BUTTON];
  assign pg_ok       = sync2_q[`MPS_SYN_PGOOD];
  assign rst_held    = !sync2_q[`MPS_SYN_RESET];
  assign alt_low     = !sync2_q[`MPS_SYN_ALT];
  assign strap_s     = sync2_q[7:4];

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [16:0] tick_cnt_q, tick_cnt_d;
  logic        tick_q,     tick_d;

  // Divider from the system clock
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 17'h0_0001;
    if (tick_cnt_q >= 17'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 17'h0_0000;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt_q <= 17'h0_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Button press classifier
  // ----------------------------------------------------------------
  logic [15:0] thresh_q, thresh_d;
  logic        short_evt;
  logic        long_evt;

  mps_press_if press_link ();

  // Button detection stays alive in every state
  assign press_link.pressed   = btn_pressed;
  assign press_link.tick      = tick_q;
  assign press_link.threshold = thresh_q;
  assign short_evt            = press_link.short_evt;
  assign long_evt             = press_link.long_evt;

  mps_press_classifier u_press (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .press    (press_link.classifier)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic                   wr_pend_q, wr_pend_d;
  logic [`MPS_ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [31:0]            rdata_q,   rdata_d;
  logic                   addr_phase;
  logic                   ctrl_keep_q, ctrl_keep_d;
  logic                   short_flag_q, short_flag_d;
  logic                   long_flag_q,  long_flag_d;
  mps_pkg::mps_state_e    state_q,   state_d;
  mps_pkg::mps_boot_e     boot_q,    boot_d;

  assign addr_phase = hsel_in && htrans_in[1] && hready_in;

  // Address phase capture and read data
  always_comb begin
    wr_pend_d = addr_phase && hwrite_in;
    wr_addr_d = wr_addr_q;
    rdata_d   = rdata_q;
    if (addr_phase) begin
      wr_addr_d = haddr_in[`MPS_ADDR_W-1:0];
      rdata_d   = 32'h0000_0000;
      if (!hwrite_in) begin
        case (haddr_in[`MPS_ADDR_W-1:0])
          `MPS_ADDR_CTRL: begin
            rdata_d = {23'h00_0000, ctrl_keep_q, 8'h00};
          end
          `MPS_ADDR_STATUS: begin
            rdata_d = {24'h00_0000, rst_held, pg_ok, long_flag_q, short_flag_q,
                       4'(state_q)};
          end
          `MPS_ADDR_THRESH: begin
            rdata_d = {16'h0000, thresh_q};
          end
          `MPS_ADDR_BOOT: begin
            rdata_d = {24'h00_0000, strap_s, alt_low, 3'(boot_q)};
          end
          default: begin
            rdata_d = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Bus registers, zero wait states, always OKAY
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_pend_q     <= 1'b0;
      wr_addr_q     <= 12'h000;
      rdata_q       <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_q     <= wr_pend_d;
      wr_addr_q     <= wr_addr_d;
      rdata_q       <= rdata_d;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  assign hrdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Control registers and power state machine
  // ----------------------------------------------------------------
  logic [2:0]          cmd_q, cmd_d;
  logic                wr_ctrl;
  logic                wr_stat;
  mps_pkg::mps_boot_e  boot_pick;

  assign wr_ctrl = wr_pend_q && wr_addr_q == `MPS_ADDR_CTRL;
  assign wr_stat = wr_pend_q && wr_addr_q == `MPS_ADDR_STATUS;

  // Strap decode with alternate-boot override
  always_comb begin
    case (strap_s)
      `MPS_STRAP_FUSE:   boot_pick = mps_pkg::MPS_BOOT_FUSE;
      `MPS_STRAP_SERIAL: boot_pick = mps_pkg::MPS_BOOT_SERIAL;
      `MPS_STRAP_EMMC:   boot_pick = mps_pkg::MPS_BOOT_EMMC;
      `MPS_STRAP_SDCARD: boot_pick = mps_pkg::MPS_BOOT_SDCARD;
      `MPS_STRAP_FLASH:  boot_pick = mps_pkg::MPS_BOOT_FLASH;
      default:           boot_pick = mps_pkg::MPS_BOOT_BAD;
    endcase
    if (alt_low) begin
      boot_pick = mps_pkg::MPS_BOOT_SERIAL;
    end
  end

  // Register writes, sticky flags and state transitions
  always_comb begin
    ctrl_keep_d  = ctrl_keep_q;
    thresh_d     = thresh_q;
    cmd_d        = 3'h0;
    short_flag_d = short_flag_q;
    long_flag_d  = long_flag_q;
    boot_d       = boot_q;
    state_d      = state_q;
    if (wr_ctrl) begin
      ctrl_keep_d = hwdata_in[`MPS_CTRL_KEEP_STBY];
      cmd_d       = hwdata_in[2:0];
    end
    if (wr_pend_q && wr_addr_q == `MPS_ADDR_THRESH) begin
      thresh_d = hwdata_in[15:0];
    end
    // Write one to clear; a new event wins
    if (wr_stat && hwdata_in[`MPS_STAT_SHORT]) begin
      short_flag_d = 1'b0;
    end
    if (wr_stat && hwdata_in[`MPS_STAT_LONG]) begin
      long_flag_d = 1'b0;
    end
    if (short_evt) begin
      short_flag_d = 1'b1;
    end
    if (long_evt) begin
      long_flag_d = 1'b1;
    end
    case (state_q)
      mps_pkg::MPS_OFF: begin
        if (pg_ok && !rst_held) begin
          state_d = mps_pkg::MPS_RUN;
          boot_d  = boot_pick;
        end
      end
      mps_pkg::MPS_AON: begin
        if (short_evt || long_evt) begin
          state_d = mps_pkg::MPS_RUN;
        end
      end
      mps_pkg::MPS_RUN: begin
        if (long_evt) begin
          state_d = mps_pkg::MPS_AON;
        end else if (cmd_q[`MPS_CTRL_GO_AON]) begin
          state_d = mps_pkg::MPS_AON;
        end else if (cmd_q[`MPS_CTRL_GO_SUSP]) begin
          state_d = mps_pkg::MPS_SUSP;
        end
      end
      mps_pkg::MPS_SUSP: begin
        if (short_evt || long_evt || cmd_q[`MPS_CTRL_GO_RUN]) begin
          state_d = mps_pkg::MPS_RUN;
        end
      end
      default: begin
        state_d = mps_pkg::MPS_OFF;
      end
    endcase
  end

  // Control state and rail outputs registered from the next state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_keep_q              <= 1'b0;
      thresh_q                 <= `MPS_LONG_MS_RST;
      cmd_q                    <= 3'h0;
      short_flag_q             <= 1'b0;
      long_flag_q              <= 1'b0;
      boot_q                   <= mps_pkg::MPS_BOOT_FUSE;
      state_q                  <= mps_pkg::MPS_OFF;
      main_rail_request_out    <= 1'b0;
      standby_rail_request_out <= 1'b0;
      core_power_out           <= 1'b0;
      power_state_out          <= 4'h1;
      boot_source_out          <= 3'h0;
      serial_download_out      <= 1'b0;
    end else begin
      ctrl_keep_q              <= ctrl_keep_d;
      thresh_q                 <= thresh_d;
      cmd_q                    <= cmd_d;
      short_flag_q             <= short_flag_d;
      long_flag_q              <= long_flag_d;
      boot_q                   <= boot_d;
      state_q                  <= state_d;
      main_rail_request_out    <= state_d == mps_pkg::MPS_RUN ||
                                  state_d == mps_pkg::MPS_SUSP;
      standby_rail_request_out <= state_d == mps_pkg::MPS_RUN ||
                                  (state_d == mps_pkg::MPS_SUSP && ctrl_keep_d);
      core_power_out           <= state_d == mps_pkg::MPS_RUN;
      power_state_out          <= 4'(state_d);
      boot_source_out          <= 3'(boot_d);
      serial_download_out      <= boot_d == mps_pkg::MPS_BOOT_SERIAL;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_main_rail_map: assert property (
    main_rail_request_out == (state_q inside {mps_pkg::MPS_RUN, mps_pkg::MPS_SUSP}))
    else $error("main rail request does not match state");
  chk_standby_rail_map: assert property (
    standby_rail_request_out == (state_q == mps_pkg::MPS_RUN ||
                                 (state_q == mps_pkg::MPS_SUSP && ctrl_keep_q)))
    else $error("standby rail request does not match state");
  chk_keep_in_suspend: assert property (
    state_q == mps_pkg::MPS_SUSP && ctrl_keep_q && !wr_ctrl |=> standby_rail_request_out)
    else $error("standby rail dropped in suspend with keep set");
  chk_long_to_aon: assert property (
    state_q == mps_pkg::MPS_RUN && long_evt |=> state_q == mps_pkg::MPS_AON ##0
    !main_rail_request_out)
    else $error("long press did not reach always-on");
  chk_short_wakes_aon: assert property (
    state_q == mps_pkg::MPS_AON && short_evt |=> state_q == mps_pkg::MPS_RUN ##0
    standby_rail_request_out)
    else $error("press in always-on did not restore runtime");
  chk_pgood_holds_off: assert property (
    state_q == mps_pkg::MPS_OFF && (!pg_ok || rst_held) |=> state_q == mps_pkg::MPS_OFF)
    else $error("boot started without power good or with reset held");
  chk_boot_starts: assert property (
    state_q == mps_pkg::MPS_OFF && pg_ok && !rst_held |=> main_rail_request_out ##0
    core_power_out)
    else $error("boot did not start with power good present");
  chk_reset_delays: assert property (
    state_q == mps_pkg::MPS_OFF && rst_held [*3] |=> state_q == mps_pkg::MPS_OFF)
    else $error("held reset button did not delay boot");
  chk_core_in_suspend: assert property (
    state_q == mps_pkg::MPS_SUSP |-> !core_power_out && main_rail_request_out)
    else $error("suspend rails or core power wrong");
  chk_alt_boot_serial: assert property (
    state_q == mps_pkg::MPS_OFF && state_d == mps_pkg::MPS_RUN && alt_low |=>
    serial_download_out && boot_source_out == 3'h1)
    else $error("alternate boot did not select serial download");
  chk_short_flag_set: assert property (
    short_evt |=> short_flag_q)
    else $error("short press not recorded");

  cov_boot: cover property (state_q == mps_pkg::MPS_OFF ##1 state_q == mps_pkg::MPS_RUN);
  cov_long_drop: cover property (state_q == mps_pkg::MPS_RUN && long_evt);
  cov_suspend_resume: cover property (state_q == mps_pkg::MPS_SUSP ##1
                                      state_q == mps_pkg::MPS_RUN);
  cov_aon_wake: cover property (state_q == mps_pkg::MPS_AON && short_evt);

endmodule

// [mps_cfg.svh]
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MPS_CLK_MHZ        100
`define MPS_TICK_US        1000
`define MPS_DEBOUNCE_MS    16'h0014
`define MPS_LONG_MS_RST    16'h0BB8

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define MPS_ADDR_W         12
`define MPS_ADDR_CTRL      12'h000
`define MPS_ADDR_STATUS    12'h004
`define MPS_ADDR_THRESH    12'h008
`define MPS_ADDR_BOOT      12'h00C
`define MPS_CTRL_GO_RUN    0
`define MPS_CTRL_GO_AON    1
`define MPS_CTRL_GO_SUSP   2
`define MPS_CTRL_KEEP_STBY 8
`define MPS_STAT_SHORT     4
`define MPS_STAT_LONG      5

// ----------------------------------------------------------------
// Synchroniser lanes and strap patterns
// ----------------------------------------------------------------
`define MPS_SYN_BUTTON     0
`define MPS_SYN_PGOOD      1
`define MPS_SYN_RESET      2
`define MPS_SYN_ALT        3
`define MPS_SYNC_RST       8'h0D
`define MPS_STRAP_FUSE     4'h0
`define MPS_STRAP_SERIAL   4'h1
`define MPS_STRAP_EMMC     4'h2
`define MPS_STRAP_SDCARD   4'h3
`define MPS_STRAP_FLASH    4'h6

`endif

// [mps_pkg.sv]
package mps_pkg;

  // Power states, one-hot
  typedef enum logic [3:0] {
    MPS_OFF  = 4'h1,
    MPS_AON  = 4'h2,
    MPS_RUN  = 4'h4,
    MPS_SUSP = 4'h8
  } mps_state_e;

  // Boot source codes
  typedef enum logic [2:0] {
    MPS_BOOT_FUSE   = 3'h0,
    MPS_BOOT_SERIAL = 3'h1,
    MPS_BOOT_EMMC   = 3'h2,
    MPS_BOOT_SDCARD = 3'h3,
    MPS_BOOT_FLASH  = 3'h4,
    MPS_BOOT_BAD    = 3'h7
  } mps_boot_e;

endpackage

// [mps_press_if.sv]
`timescale 1ns/1ps

// Button press classification link
interface mps_press_if;
  logic        pressed;
  logic        tick;
  logic [15:0] threshold;
  logic        short_evt;
  logic        long_evt;

  modport classifier (
    input  pressed,
    input  tick,
    input  threshold,
    output short_evt,
    output long_evt
  );

  modport owner (
    output pressed,
    output tick,
    output threshold,
    input  short_evt,
    input  long_evt
  );
endinterface

// [mps_press_classifier.sv]
`timescale 1ns/1ps
`include "mps_cfg.svh"

module mps_press_classifier (
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  mps_press_if.classifier press
);

  logic        stable_q,    stable_d;
  logic [15:0] deb_cnt_q,   deb_cnt_d;
  logic [15:0] hold_cnt_q,  hold_cnt_d;
  logic        long_done_q, long_done_d;
  logic        short_q,     short_d;
  logic        long_q,      long_d;

  // Debounce, hold timing and event generation
  always_comb begin
    stable_d    = stable_q;
    deb_cnt_d   = deb_cnt_q;
    hold_cnt_d  = hold_cnt_q;
    long_done_d = long_done_q;
    short_d     = 1'b0;
    long_d      = 1'b0;
    if (press.pressed != stable_q) begin
      if (press.tick) begin
        deb_cnt_d = deb_cnt_q + 16'h0001;
        if (deb_cnt_d >= `MPS_DEBOUNCE_MS) begin
          stable_d  = press.pressed;
          deb_cnt_d = 16'h0000;
        end
      end
    end else begin
      deb_cnt_d = 16'h0000;
    end
    if (stable_q) begin
      if (press.tick && hold_cnt_q != 16'hFFFF) begin
        hold_cnt_d = hold_cnt_q + 16'h0001;
      end
      if (!long_done_q && hold_cnt_q >= press.threshold) begin
        long_d      = 1'b1;
        long_done_d = 1'b1;
      end
      if (!stable_d) begin
        short_d     = !long_done_q && !long_d;
        hold_cnt_d  = 16'h0000;
        long_done_d = 1'b0;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stable_q    <= 1'b0;
      deb_cnt_q   <= 16'h0000;
      hold_cnt_q  <= 16'h0000;
      long_done_q <= 1'b0;
      short_q     <= 1'b0;
      long_q      <= 1'b0;
    end else begin
      stable_q    <= stable_d;
      deb_cnt_q   <= deb_cnt_d;
      hold_cnt_q  <= hold_cnt_d;
      long_done_q <= long_done_d;
      short_q     <= short_d;
      long_q      <= long_d;
    end
  end

  assign press.short_evt = short_q;
  assign press.long_evt  = long_q;

  // Long event once the hold reaches the threshold
  chk_long_at_threshold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    stable_q && !long_done_q && hold_cnt_q >= press.threshold |=> long_q)
    else $error("long press not flagged at threshold");

endmodule

// [mps_carrier_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Carrier board power control model
// ----------------------------------------
module mps_carrier_model (
  input  wire logic       hold_off_in,
  input  wire logic       press_in,
  input  wire logic [3:0] power_state_in,
  output logic            power_good_out,
  output logic            power_button_n_out
);
  logic in_susp;

  // Open-drain power good, released level is the pull-up
  assign in_susp        = power_state_in === mps_pkg::MPS_SUSP;
  assign power_good_out = !(hold_off_in && !in_susp);

  // Button only pulls low, allowed whether the main rail is on or off
  assign power_button_n_out = !press_in;
endmodule

// [test_mps_sequencer.sv]
`timescale 1ns/1ps
`include "mps_cfg.svh"

module test_mps_sequencer;
  logic        clk_in, rst_n_in, hsel, hwrite, hold_off, press, rb_n, alt_n;
  logic        hready, hresp, main, stby, core, pgood, pb_n, sdl;
  logic [1:0]  htrans;
  logic [3:0]  strap, pstate;
  logic [2:0]  bsrc, hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0]  tbl [7];
  int          errors, compares;

  // ----------------------------------------
  // Design and carrier
  // ----------------------------------------
  mps_sequencer #(.TICK_CYCLES(10)) mps_sequencer_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .power_button_n_in(pb_n), .power_good_in(pgood), .reset_button_n_in(rb_n),
    .alternate_boot_n_in(alt_n), .boot_select_strap_in(strap),
    .main_rail_request_out(main), .standby_rail_request_out(stby),
    .core_power_out(core), .power_state_out(pstate), .boot_source_out(bsrc),
    .serial_download_out(sdl));

  mps_carrier_model mps_carrier_model_i (
    .hold_off_in(hold_off), .press_in(press), .power_state_in(pstate),
    .power_good_out(pgood), .power_button_n_out(pb_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Single AHB transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    // Address phase stands until hready is seen high at a rising edge
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    // Data phase stands until hready high again; read data taken there
    do @(posedge clk_in); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, r, exp);
  endtask

  // Compare state and rail outputs at a settled point
  task automatic pins(input logic [6:0] exp, input string nm);
    @(negedge clk_in);
    chk(nm, {25'h0, pstate, main, stby, core}, {25'h0, exp});
    @(posedge clk_in);
  endtask

  task automatic push(input int n);
    @(posedge clk_in);
    press <= 1'b1;
    repeat (n) @(posedge clk_in);
    press <= 1'b0;
    repeat (300) @(posedge clk_in);
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask

  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Cut a hang well past the expected run length
  initial begin
    #200_000;
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {rst_n_in, hsel, hwrite, htrans, haddr, hwdata, hsize, press, rb_n} = '0;
    hold_off = 1'b1;
    alt_n    = 1'b1;
    strap    = 4'h2;
    errors   = 0;
    compares = 0;
    tbl      = '{8'h80, 8'h89, 8'h92, 8'h9B, 8'hB4, 8'hAF, 8'h11};
    do_reset();
    repeat (20) @(posedge clk_in);
    pins({mps_pkg::MPS_OFF, 3'b000}, "off held");
    hold_off <= 1'b0;
    repeat (20) @(posedge clk_in);
    pins({mps_pkg::MPS_OFF, 3'b000}, "reset_button_n hold");
    rb_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    pins({mps_pkg::MPS_RUN, 3'b111}, "boot run");
    rd(`MPS_ADDR_THRESH, 32'h0000_0BB8, "thresh rst");
    rd(12'h010, 32'h0000_0000, "unmapped");
    fin("power_up");
    // Boot source table, alternate boot last
    foreach (tbl[i]) begin
      alt_n <= tbl[i][7];
      strap <= tbl[i][6:3];
      do_reset();
      repeat (10) @(posedge clk_in);
      @(negedge clk_in);
      chk("boot src", {29'h0, bsrc}, {29'h0, tbl[i][2:0]});
      chk("serial dl", {31'h0, sdl}, {31'h0, tbl[i][2:0] == 3'h1});
      @(posedge clk_in);
    end
    fin("boot_select");
    wr_thresh: begin
      // 60 ms: a 35 ms hold stays short, an 80 ms hold goes long
      xfer(1'b1, `MPS_ADDR_THRESH, 32'h0000_003C);
    end
    push(350);
    pins({mps_pkg::MPS_RUN, 3'b111}, "short run");
    rd(`MPS_ADDR_STATUS, 32'h0000_0054, "short flag");
    xfer(1'b1, `MPS_ADDR_STATUS, 32'h0000_0010);
    rd(`MPS_ADDR_STATUS, 32'h0000_0044, "flag clear");
    fin("short_press");
    xfer(1'b1, `MPS_ADDR_CTRL, 32'h0000_0004);
    repeat (3) @(posedge clk_in);
    pins({mps_pkg::MPS_SUSP, 3'b100}, "suspend");
    xfer(1'b1, `MPS_ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    pins({mps_pkg::MPS_RUN, 3'b111}, "resume");
    xfer(1'b1, `MPS_ADDR_CTRL, 32'h0000_0104);
    repeat (3) @(posedge clk_in);
    pins({mps_pkg::MPS_SUSP, 3'b110}, "keep stby");
    rd(`MPS_ADDR_CTRL, 32'h0000_0100, "keep bit");
    push(350);
    pins({mps_pkg::MPS_RUN, 3'b111}, "susp wake");
    fin("suspend");
    push(800);
    pins({mps_pkg::MPS_AON, 3'b000}, "long aon");
    xfer(1'b0, `MPS_ADDR_STATUS, 32'h0000_0000);
    chk("long flag", r & 32'h0000_002F, 32'h0000_0022);
    push(350);
    pins({mps_pkg::MPS_RUN, 3'b111}, "aon wake");
    fin("long_press");
    tally_and_finish();
  end
endmodule
